//--- inc/stm_pkg.sv
// Constants, field layouts and carrier types of the sixteen-bit timer
package stm_pkg;
  // ==========================================================================
  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PIN_W = 2;
  localparam int SYNC_W = 3;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] COUNT_LOW_OFS = 4'h1;
  localparam logic [3:0] COUNT_HIGH_OFS = 4'h2;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h3;
  localparam logic [3:0] IRQ_ENABLE_OFS = 4'h4;
  localparam logic [3:0] IRQ_CLEAR_OFS = 4'h5;

  // ==========================================================================
  // Control field positions
  localparam int RUN_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int SYNC_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int PS_LO_BIT = 4;
  localparam int PS_HI_BIT = 5;
  localparam int STS_BIT = 6;
  localparam int WIDE_BIT = 7;

  // ==========================================================================
  // Interrupt bit positions
  localparam int IRQ_OVF_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================================
  // Prescale codes and terminal counts
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_DIV8 = 2'h3;
  localparam logic [2:0] PS_LAST1 = 3'h0;
  localparam logic [2:0] PS_LAST2 = 3'h1;
  localparam logic [2:0] PS_LAST4 = 3'h3;
  localparam logic [2:0] PS_LAST8 = 3'h7;

  // ==========================================================================
  // Timing: instruction cycle is the master clock divided by four
  localparam int CLK_HZ = 100_000_000;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

  // ==========================================================================
  // Pin indices in the synchronised input vector
  localparam int PIN_XOUT = 0;
  localparam int PIN_XIN = 1;
  localparam int OSC_IDX = 2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic wide;
    logic sysclk_sts;
    logic [1:0] prescale;
    logic osc_en;
    logic sync_bypass;
    logic src_ext;
    logic run;
  } stm_ctrl_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stm_bus_req_type;
endpackage

//--- testbench/stm_ext_src.sv
// Behavioural external clock source: pin clock or crystal output
`timescale 1ns/1ps
module stm_ext_src;
  logic o_clk = 1'b0;
  // Clock stands low between bursts
  task automatic burst(input int n, input int half);
    #3;
    repeat (n) begin
      #half o_clk = 1'b1;
      #half o_clk = 1'b0;
    end
  endtask
endmodule

//--- testbench/stm_timer_props.sv
// Port checker of the sixteen-bit timer
`timescale 1ns/1ps
module stm_timer_props (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire stm_pkg::stm_bus_req_type i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_special_event_reset,
  input wire logic i_sysclk_from_crystal,
  input wire logic [1:0] o_pin_oe,
  input wire logic [1:0] o_port_read,
  input wire logic o_crystal_osc_enable,
  input wire logic [15:0] o_count,
  input wire logic o_overflow
);
  // ==========================================================================
  // Settling time after reset release
  logic [2:0] up_q;
  logic up;
  logic ctl_wr;
  logic ctl_rd;
  logic lo_wr;
  assign up = (up_q == 3'h7);
  assign ctl_wr = i_bus.wr && (i_bus.addr == stm_pkg::CTRL_OFS);
  assign ctl_rd = i_bus.rd && (i_bus.addr == stm_pkg::CTRL_OFS);
  assign lo_wr = i_bus.wr && (i_bus.addr == stm_pkg::COUNT_LOW_OFS);
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      up_q <= 3'h0;
    end else if (!up) begin
      up_q <= up_q + 3'h1;
    end
  end
  // ==========================================================================
  // Properties
  default clocking dcb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);
  a_rdata_idle: assert property (up && !$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_status_live: assert property (up && $past(ctl_rd)
    |-> o_rdata[6] == $past(i_sysclk_from_crystal))
    else $error("status bit does not follow the clock source");
  a_osc_pins_in: assert property (o_crystal_osc_enable && $past(o_crystal_osc_enable)
    |-> o_pin_oe == 2'h0 && o_port_read == 2'h0)
    else $error("oscillator pins driven or read back");
  a_osc_by_write: assert property (up && $changed(o_crystal_osc_enable)
    |-> $past(ctl_wr) && o_crystal_osc_enable == $past(i_bus.wdata[3]))
    else $error("oscillator enable moved without a write");
  a_low_write: assert property (up && $past(lo_wr) |-> o_count[7:0] == $past(i_bus.wdata))
    else $error("low byte write lost");
  a_sev_clears: assert property (up && $past(i_special_event_reset) && !$past(i_bus.wr)
    |-> o_count == 16'h0000)
    else $error("trigger did not clear the counter");
  a_count_step: assert property (up && !$past(i_bus.wr) && !$past(i_special_event_reset)
    && $changed(o_count) |-> o_count == $past(o_count) + 16'h0001)
    else $error("counter moved by other than one");
  a_ovf_wrap: assert property (up && o_overflow
    |-> $past(o_count) == 16'hFFFF || $past(o_count, 2) == 16'hFFFF)
    else $error("overflow without a wrap");
  a_ovf_pulse: assert property (o_overflow |=> !o_overflow)
    else $error("overflow pulse too long");
  a_sev_noflag: assert property (i_special_event_reset |=> !o_overflow)
    else $error("trigger raised overflow");
  c_ovf: cover property (o_overflow);
  c_sev: cover property (i_special_event_reset);
  c_osc: cover property (o_crystal_osc_enable);
endmodule
bind stm_timer stm_timer_props u_props (.i_mclk, .i_arst_n, .i_bus, .o_rdata,
  .i_special_event_reset, .i_sysclk_from_crystal, .o_pin_oe, .o_port_read,
  .o_crystal_osc_enable, .o_count, .o_overflow);

//--- testbench/tb_stm_timer.sv
// Self-checking testbench of the sixteen-bit timer
`timescale 1ns/1ps
module tb_stm_timer;
  localparam logic [3:0] A_CTL = stm_pkg::CTRL_OFS;
  localparam logic [3:0] A_LO = stm_pkg::COUNT_LOW_OFS;
  localparam logic [3:0] A_HI = stm_pkg::COUNT_HIGH_OFS;
  localparam logic [3:0] A_ST = stm_pkg::IRQ_STATUS_OFS;
  localparam logic [3:0] A_EN = stm_pkg::IRQ_ENABLE_OFS;
  localparam logic [3:0] A_CL = stm_pkg::IRQ_CLEAR_OFS;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic sev = 1'b0;
  logic sleep = 1'b0;
  logic sysclk = 1'b0;
  logic [1:0] dout = 2'h2;
  logic [1:0] dir = 2'h1;
  stm_pkg::stm_bus_req_type bus = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] port_read;
  logic osc_en;
  logic ovf;
  logic irq;
  logic [15:0] count;
  int n_errors = 0;
  int n_tests = 0;
  always #5 i_mclk = ~i_mclk;
  stm_ext_src u_pin ();
  stm_ext_src u_xtal ();
  stm_timer u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_bus(bus), .o_rdata(rdata),
    .i_special_event_reset(sev), .i_core_sleep(sleep), .i_sysclk_from_crystal(sysclk),
    .i_crystal_osc(u_xtal.o_clk), .i_pin_in({1'b1, u_pin.o_clk}), .i_pin_dout(dout),
    .i_osc_pin_direction_bits(dir), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_port_read(port_read), .o_crystal_osc_enable(osc_en), .o_count(count), .o_overflow(ovf),
    .o_irq(irq));
  // ==========================================================================
  // Bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus <= '0;
    #1;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus <= '0;
    #1 v = rdata;
    chk({8'h00, v}, {8'h00, e});
  endtask
  task automatic wait_cnt(input logic [15:0] val, output int c);
    c = 0;
    while (count !== val && c < 500) begin
      settle(1);
      c++;
    end
  endtask
  task automatic ext_run(input logic [7:0] c, input bit xtal, input int half);
    logic [15:0] s;
    wr(A_CTL, c);
    settle(10);
    s = count;
    if (xtal) begin
      u_xtal.burst(5, half);
    end else begin
      u_pin.burst(5, half);
    end
    settle(10);
    chk(count, s + 16'h0005);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rchk(A_CTL, 8'h00);
    rchk(A_HI, 8'h00);
    rchk(A_ST, 8'h00);
    rchk(4'hF, 8'h00);
    @(posedge i_mclk) sysclk <= 1'b1;
    rchk(A_CTL, 8'h40);
    @(posedge i_mclk) sysclk <= 1'b0;
    wr(A_CTL, 8'h40);
    rchk(A_CTL, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_prescale;
    int c;
    logic [15:0] s;
    for (int p = 0; p < 4; p++) begin
      wr(A_CTL, 8'h00);
      wr(A_LO, 8'h00);
      wr(A_HI, 8'h00);
      wr(A_CTL, {2'b00, p[1:0], 4'b0001});
      wait_cnt(16'h0001, c);
      wait_cnt(16'h0003, c);
      chk(16'(c), 16'(8 << p));
    end
    wr(A_CTL, 8'h00);
    s = count;
    settle(40);
    chk(count, s);
    $display("t_prescale done");
  endtask
  task automatic t_wide;
    logic [15:0] s;
    wr(A_CTL, 8'h80);
    s = count;
    wr(A_HI, 8'h12);
    chk(count, s);
    wr(A_LO, 8'h34);
    chk(count, 16'h1234);
    wr(A_CTL, 8'h00);
    wr(A_HI, 8'h56);
    chk(count, 16'h5634);
    wr(A_CTL, 8'h80);
    rchk(A_HI, 8'h12);
    rchk(A_LO, 8'h34);
    rchk(A_HI, 8'h56);
    $display("t_wide done");
  endtask
  task automatic t_irq;
    int c;
    wr(A_CTL, 8'h00);
    wr(A_HI, 8'hFF);
    wr(A_LO, 8'hFE);
    wr(A_CTL, 8'h01);
    for (c = 0; c < 100 && ovf !== 1'b1; c++) settle(1);
    chk(16'(ovf), 16'h0001);
    chk(count, 16'h0000);
    wr(A_CTL, 8'h00);
    rchk(A_ST, 8'h01);
    chk(16'(irq), 16'h0000);
    wr(A_EN, 8'h01);
    settle(2);
    chk(16'(irq), 16'h0001);
    wr(A_CL, 8'h01);
    settle(2);
    chk(16'(irq), 16'h0000);
    rchk(A_ST, 8'h00);
    $display("t_irq done");
  endtask
  task automatic t_sev;
    logic [15:0] s;
    wr(A_CTL, 8'h80);
    wr(A_HI, 8'h10);
    wr(A_LO, 8'h00);
    wr(A_CTL, 8'h81);
    @(posedge i_mclk) sev <= 1'b1;
    @(posedge i_mclk) sev <= 1'b0;
    #1 chk(count, 16'h0000);
    rchk(A_ST, 8'h00);
    wr(A_CTL, 8'h80);
    wr(A_HI, 8'h44);
    @(posedge i_mclk);
    bus <= '{addr: A_LO, wdata: 8'h77, wr: 1'b1, rd: 1'b0};
    sev <= 1'b1;
    @(posedge i_mclk);
    bus <= '0;
    sev <= 1'b0;
    #1 chk(count, 16'h4477);
    // Trigger lands on the tick that would wrap the counter
    wr(A_CTL, 8'h00);
    wr(A_HI, 8'hFF);
    wr(A_CTL, 8'h01);
    s = count;
    for (int k = 0; k < 10 && count === s; k++) settle(1);
    @(posedge i_mclk) bus <= '{addr: A_LO, wdata: 8'hFF, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk) bus <= '0;
    @(posedge i_mclk) sev <= 1'b1;
    @(posedge i_mclk) sev <= 1'b0;
    #1 chk(count, 16'h0000);
    chk(16'(ovf), 16'h0000);
    rchk(A_ST, 8'h00);
    wr(A_CTL, 8'h00);
    $display("t_sev done");
  endtask
  task automatic t_ext;
    wr(A_CTL, 8'h00);
    chk({14'h0, pin_oe}, 16'h0002);
    chk({14'h0, port_read}, 16'h0002);
    chk({14'h0, pin_out}, 16'h0002);
    ext_run(8'h03, 1'b0, 40);
    ext_run(8'h07, 1'b0, 40);
    ext_run(8'h0F, 1'b1, 40);
    chk(16'(osc_en), 16'h0001);
    chk({14'h0, pin_oe}, 16'h0000);
    chk({14'h0, port_read}, 16'h0000);
    @(posedge i_mclk) sleep <= 1'b1;
    ext_run(8'h0F, 1'b1, 40);
    @(posedge i_mclk) sleep <= 1'b0;
    wr(A_CTL, 8'h00);
    chk(16'(osc_en), 16'h0000);
    $display("t_ext done");
  endtask
  task automatic give_verdict;
    $display("TB: %0d mismatches in %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    t_reset();
    t_prescale();
    t_wide();
    t_irq();
    t_sev();
    t_ext();
    give_verdict();
  end
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule

//--- verilog/stm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module stm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] lvl_q;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] lvl_d;

  // ==========================================================================
  // Level follows only once stage two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign lvl_d = (agree & s3_q) | (~agree & lvl_q);
  assign o_level = lvl_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else if (i_ce) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
endmodule

//--- verilog/stm_timer.sv
// Sixteen-bit timer with crystal oscillator control, prescaler and overflow interrupt
//
// Operation
// - Count only while run bit set
// - Top bit selects wide or byte access
// - Bit six shows crystal drives sysclk
// - Two-bit prescale divides by one to eight
// - Bit three powers the crystal oscillator
// - Bit two bypasses external synchroniser
// - Bit one picks internal or external source
// - Advance per instruction cycle or rising edge
// - Oscillator on: pins inputs, read zero
// - Compare trigger input clears the counter
// - Counter read and written as bytes
// - Wrap to zero raises overflow event
// - Oscillator keeps running in sleep
// - Wide mode: low read latches high
// - Wide high write buffered, low loads
// - Trigger sets no flag; write wins
// - Overflow sticky flag gated by enable
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module stm_timer (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire stm_pkg::stm_bus_req_type i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_special_event_reset,
  input wire logic i_core_sleep,
  input wire logic i_sysclk_from_crystal,
  input wire logic i_crystal_osc,
  input wire logic [1:0] i_pin_in,
  input wire logic [1:0] i_pin_dout,
  input wire logic [1:0] i_osc_pin_direction_bits,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe,
  output logic [1:0] o_port_read,
  output logic o_crystal_osc_enable,
  output logic [15:0] o_count,
  output logic o_overflow,
  output logic o_irq
);
  // ==========================================================================
  // Reset release
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n = rst_s2_q;

  // ==========================================================================
  // State
  stm_pkg::stm_ctrl_type ctrl_q;
  stm_pkg::stm_ctrl_type ctrl_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0] high_buf_q;
  logic [7:0] high_buf_d;
  logic [2:0] presc_q;
  logic [2:0] presc_d;
  logic [1:0] instr_div_q;
  logic ext_prev_q;
  logic sync_p1_q;
  logic sync_p2_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_status_d;
  logic [7:0] irq_enable_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic ovf_q;
  logic [1:0] pin_out_q;
  logic [1:0] pin_oe_q;
  logic [1:0] port_read_q;
  logic [15:0] count_out_q;

  // ==========================================================================
  // Address decode
  wire wr_ctrl = i_bus.wr && (i_bus.addr == stm_pkg::CTRL_OFS);
  wire wr_low = i_bus.wr && (i_bus.addr == stm_pkg::COUNT_LOW_OFS);
  wire wr_high = i_bus.wr && (i_bus.addr == stm_pkg::COUNT_HIGH_OFS);
  wire wr_irq_en = i_bus.wr && (i_bus.addr == stm_pkg::IRQ_ENABLE_OFS);
  wire wr_irq_clr = i_bus.wr && (i_bus.addr == stm_pkg::IRQ_CLEAR_OFS);
  wire rd_low = i_bus.rd && (i_bus.addr == stm_pkg::COUNT_LOW_OFS);

  // ==========================================================================
  // Control register
  // Status bit is not stored; it is read live from the clock controller
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = stm_pkg::stm_ctrl_type'(i_bus.wdata);
      ctrl_d.sysclk_sts = 1'b0;
    end
  end

  wire [7:0] ctrl_rd = {ctrl_q.wide, i_sysclk_from_crystal,
                        ctrl_q.prescale, ctrl_q.osc_en, ctrl_q.sync_bypass,
                        ctrl_q.src_ext, ctrl_q.run};

  // ==========================================================================
  // Input synchronisers: crystal output and both oscillator pins
  logic [2:0] sync_lvl;

  stm_sync #(
    .WIDTH(stm_pkg::SYNC_W)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_ce(i_ce),
    .i_async({i_crystal_osc, i_pin_in}),
    .o_level(sync_lvl)
  );

  // ==========================================================================
  // Count source
  // Enabled oscillator replaces the external pin as the edge source
  wire ext_lvl = ctrl_q.osc_en ? sync_lvl[stm_pkg::OSC_IDX]
                               : sync_lvl[stm_pkg::PIN_XOUT];
  wire ext_edge = ext_lvl && !ext_prev_q;
  // Instruction clock stops while the core sleeps
  wire instr_tick = !i_core_sleep && (instr_div_q == stm_pkg::INSTR_LAST);
  // Synchronised path runs on the master clock but is gated off while the core sleeps, so it halts in sleep
  wire sync_edge = sync_p2_q && !i_core_sleep;
  wire ext_tick = ctrl_q.sync_bypass ? ext_edge : sync_edge;
  wire src_tick = ctrl_q.src_ext ? ext_tick : instr_tick;
  wire run_tick = ctrl_q.run && src_tick;

  // ==========================================================================
  // Prescaler
  logic [2:0] presc_last;

  always_comb begin
    case (ctrl_q.prescale)
      stm_pkg::PS_DIV1: presc_last = stm_pkg::PS_LAST1;
      stm_pkg::PS_DIV2: presc_last = stm_pkg::PS_LAST2;
      stm_pkg::PS_DIV4: presc_last = stm_pkg::PS_LAST4;
      stm_pkg::PS_DIV8: presc_last = stm_pkg::PS_LAST8;
      default: presc_last = stm_pkg::PS_LAST1;
    endcase
  end

  wire presc_hit = presc_q >= presc_last;
  wire count_tick = run_tick && presc_hit;
  // Any counter write clears the prescaler, except a buffered high write
  wire presc_clr = wr_low || (wr_high && !ctrl_q.wide);

  always_comb begin
    presc_d = presc_q;
    if (presc_clr || i_special_event_reset) begin
      presc_d = 3'h0;
    end else if (run_tick) begin
      presc_d = presc_hit ? 3'h0 : presc_q + 3'h1;
    end
  end

  // ==========================================================================
  // Counter and high byte buffer
  wire cnt_write = wr_low || (wr_high && !ctrl_q.wide);
  // A trigger reset swallows the tick, so no wrap is seen
  wire ovf_evt = count_tick && !cnt_write && !i_special_event_reset
                 && (count_q == stm_pkg::COUNT_MAX);

  always_comb begin
    count_d = count_q;
    high_buf_d = high_buf_q;
    if (wr_low) begin
      if (ctrl_q.wide) begin
        count_d = {high_buf_q, i_bus.wdata};
      end else begin
        count_d = {count_q[15:8], i_bus.wdata};
      end
    end else if (wr_high) begin
      if (ctrl_q.wide) begin
        high_buf_d = i_bus.wdata;
      end else begin
        count_d = {i_bus.wdata, count_q[7:0]};
      end
    end else if (i_special_event_reset) begin
      count_d = stm_pkg::COUNT_RESET;
    end else if (count_tick) begin
      count_d = count_q + 16'h0001;
    end
    if (rd_low && ctrl_q.wide) begin
      high_buf_d = count_q[15:8];
    end
  end

  // ==========================================================================
  // Interrupt status, enable and clear
  // A new overflow beats a simultaneous clear
  wire [7:0] irq_set = {7'h00, ovf_evt};
  wire [7:0] irq_clr = wr_irq_clr ? i_bus.wdata : stm_pkg::IRQ_RESET;

  assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

  // ==========================================================================
  // Read mux
  always_comb begin
    rdata_d = stm_pkg::BYTE_ZERO;
    if (i_bus.rd) begin
      case (i_bus.addr)
        stm_pkg::CTRL_OFS: rdata_d = ctrl_rd;
        stm_pkg::COUNT_LOW_OFS: rdata_d = count_q[7:0];
        stm_pkg::COUNT_HIGH_OFS: rdata_d = ctrl_q.wide ? high_buf_q
                                                      : count_q[15:8];
        stm_pkg::IRQ_STATUS_OFS: rdata_d = irq_status_q;
        stm_pkg::IRQ_ENABLE_OFS: rdata_d = irq_enable_q;
        default: rdata_d = stm_pkg::BYTE_ZERO;
      endcase
    end
  end

  // ==========================================================================
  // Pin control
  // Enabled oscillator forces both pins to inputs reading zero
  wire [1:0] pin_oe_d = ctrl_q.osc_en ? 2'h0 : ~i_osc_pin_direction_bits;
  wire [1:0] port_read_d = ctrl_q.osc_en ? 2'h0
                                         : sync_lvl[stm_pkg::PIN_XIN:stm_pkg::PIN_XOUT];

  // ==========================================================================
  // Timebase and edge pipeline
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_div_q <= 2'h0;
      ext_prev_q <= 1'b0;
      sync_p1_q <= 1'b0;
      sync_p2_q <= 1'b0;
    end else if (i_ce) begin
      if (!i_core_sleep) begin
        instr_div_q <= instr_div_q + 2'h1;
      end
      ext_prev_q <= ext_lvl;
      sync_p1_q <= ext_edge;
      sync_p2_q <= sync_p1_q;
    end
  end

  // ==========================================================================
  // Registers and counter
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= stm_pkg::stm_ctrl_type'(stm_pkg::CTRL_RESET);
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= stm_pkg::COUNT_RESET;
    end else if (i_ce) begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      high_buf_q <= stm_pkg::BYTE_ZERO;
    end else if (i_ce) begin
      high_buf_q <= high_buf_d;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 3'h0;
    end else if (i_ce) begin
      presc_q <= presc_d;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= stm_pkg::IRQ_RESET;
    end else if (i_ce) begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_enable_q <= stm_pkg::IRQ_RESET;
    end else if (i_ce && wr_irq_en) begin
      irq_enable_q <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (i_ce) begin
      irq_q <= |(irq_status_q & irq_enable_q);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (i_ce) begin
      ovf_q <= ovf_evt;
    end
  end

  // ==========================================================================
  // Output flops
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= stm_pkg::BYTE_ZERO;
      pin_out_q <= 2'h0;
      pin_oe_q <= 2'h0;
      port_read_q <= 2'h0;
      count_out_q <= stm_pkg::COUNT_RESET;
    end else if (i_ce) begin
      rdata_q <= rdata_d;
      pin_out_q <= i_pin_dout;
      pin_oe_q <= pin_oe_d;
      port_read_q <= port_read_d;
      count_out_q <= count_d;
    end
  end

  // Oscillator enable is not gated by sleep so timekeeping survives it
  assign o_crystal_osc_enable = ctrl_q.osc_en;
  assign o_rdata = rdata_q;
  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_port_read = port_read_q;
  assign o_count = count_out_q;
  assign o_overflow = ovf_q;
  assign o_irq = irq_q;
endmodule
